/* File: hw/pscpl_ctrl.sv */
`timescale 1ns/10ps
module pscpl_ctrl
   import pscpl_pkg::*;
#(
   parameter int FILTER_CYC = PSCPL_FILTER_CYC, // [R14]
   parameter int LOCKOUT_CYC = PSCPL_FILTER_CYC
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic out_enable_n_i,
   input wire logic main_hold_n_i,
   input wire logic slot_addr_bit0_n_i,
   input wire logic slot_addr_bit1_n_i,
   input wire logic sw_priority_i,
   input wire logic sw_main_on_i,
   input wire logic supply_ready_i,
   input wire logic out_of_spec_i,
   output logic main_rails_on_o,
   output logic aux_3v3_rail_o,
   output logic [6:0] i2c_addr_primary_o,
   output logic [6:0] i2c_addr_redundant_o,
   output logic addr_valid_o,
   output logic system_hold_n_pd_o,
   output logic fault_flag_n_pd_o
);
   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [3:0] raw;
      logic [3:0] flt;
      logic [3:0][PSCPL_CNT_W-1:0] cnt;
      logic [PSCPL_CNT_W-1:0] lock_cnt;
      logic [1:0] addr;
      logic addr_done;
      logic ready;
      pscpl_out_t mode;
   } pscpl_state_t;

   pscpl_state_t st_r;
   pscpl_state_t st_nxt;
   logic [3:0] pins;
   logic [3:0] stable;
   logic want_main;
   logic want_aux;
   localparam logic [PSCPL_CNT_W-1:0] FILT_LAST = PSCPL_CNT_W'(FILTER_CYC - 1);
   localparam logic [PSCPL_CNT_W-1:0] LOCK_LOAD = PSCPL_CNT_W'(LOCKOUT_CYC);

   assign pins = {slot_addr_bit1_n_i, slot_addr_bit0_n_i, main_hold_n_i, out_enable_n_i};

   // Each input must hold a new level for the full interval before it is accepted.
   for (genvar i = 0; i < 4; i++) begin : g_filt
      assign stable[i] = (st_r.raw[i] == pins[i]) && (st_r.cnt[i] == FILT_LAST); // [R2] [R5]
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      st_nxt.raw = pins;
      // The counter runs while a pin keeps its level and rests at the last count.
      // Pins that never move settle too, so the slot pins at their idle level are usable.
      for (int i = 0; i < 4; i++) begin
         if (st_r.raw[i] != pins[i]) begin
            st_nxt.cnt[i] = '0;
         end else if (stable[i]) begin
            st_nxt.flt[i] = pins[i]; // [R2] [R5]
         end else begin
            st_nxt.cnt[i] = st_r.cnt[i] + PSCPL_CNT_W'(1);
         end
      end
      // The address is taken once, after the first full filter window since reset.
      if (!st_r.addr_done && stable[2] && stable[3]) begin // [R5] [R7]
         st_nxt.addr = ~pins[3:2]; // [R4] [R6]
         st_nxt.addr_done = 1'b1;
      end
      // Ready stays set until reset, so a later drop of the supply input is ignored.
      if (st_r.addr_done && !st_r.ready && supply_ready_i) begin
         st_nxt.ready = 1'b1; // [R12]
      end
      want_aux = st_r.ready && !st_r.flt[0]; // [R1]
      want_main = want_aux && (sw_priority_i ? sw_main_on_i : st_r.flt[1]); // [R13]
      if (st_r.lock_cnt != '0) begin
         st_nxt.lock_cnt = st_r.lock_cnt - PSCPL_CNT_W'(1);
      end
      unique case (st_r.mode)
         PSCPL_OFF: begin
            if (want_aux && st_r.lock_cnt == '0) begin // [R3]
               st_nxt.mode = want_main ? PSCPL_ALL : PSCPL_AUX;
               st_nxt.lock_cnt = LOCK_LOAD;
            end
         end
         PSCPL_AUX: begin
            if (!want_aux) begin
               st_nxt.mode = PSCPL_OFF;
            end else if (want_main && st_r.lock_cnt == '0) begin // [R3]
               st_nxt.mode = PSCPL_ALL;
               st_nxt.lock_cnt = LOCK_LOAD;
            end
         end
         PSCPL_ALL: begin
            if (!want_aux) begin
               st_nxt.mode = PSCPL_OFF;
            end else if (!want_main) begin
               st_nxt.mode = PSCPL_AUX;
            end
         end
         default: st_nxt.mode = PSCPL_OFF;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         st_r <= '{raw: 4'hF, flt: 4'hF, cnt: '0, lock_cnt: '0, addr: 2'h0,
                   addr_done: 1'b0, ready: 1'b0, mode: PSCPL_OFF};
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign main_rails_on_o = (st_r.mode == PSCPL_ALL);
   assign aux_3v3_rail_o = (st_r.mode != PSCPL_OFF);
   assign i2c_addr_primary_o = PSCPL_ADDR_BASE | {5'h00, st_r.addr}; // [R8]
   assign i2c_addr_redundant_o = PSCPL_ADDR_BASE | {5'h00, st_r.addr}; // [R8]
   assign addr_valid_o = st_r.addr_done;
   assign system_hold_n_pd_o = !st_r.ready; // [R11] [R15]
   assign fault_flag_n_pd_o = st_r.ready ? out_of_spec_i : !st_r.ready; // [R9] [R10] [R15]

   ////////////////////////////////////////////////////////////////////////////////
   sequence en_seen_s;
      !st_r.raw[0] && !out_enable_n_i;
   endsequence

   addr_frozen_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R7]
      st_r.addr_done |=> $stable(st_r.addr) && st_r.addr_done)
      else $error("slot address changed after capture");
   addr_map_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R4]
      i2c_addr_primary_o[6:2] == 5'h08)
      else $error("address outside 20h to 23h");
   ports_same_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R8]
      i2c_addr_primary_o == i2c_addr_redundant_o)
      else $error("port addresses differ");
   hold_low_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R11]
      !st_r.ready |-> system_hold_n_pd_o)
      else $error("system hold released during power-up");
   fault_track_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R9]
      !st_r.ready |-> fault_flag_n_pd_o == system_hold_n_pd_o)
      else $error("fault flag not tracking system hold");
   fault_spec_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R10]
      st_r.ready |-> fault_flag_n_pd_o == out_of_spec_i)
      else $error("fault flag wrong after power-up");
   off_when_dis_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R1]
      st_r.flt[0] |=> !aux_3v3_rail_o)
      else $error("outputs on while enable inactive");
   glitch_ign_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R2]
      ((st_r.flt[0] && !stable[0]) and en_seen_s) ##1 out_enable_n_i |=> st_r.flt[0])
      else $error("enable glitch accepted");
   lockout_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R3]
      $rose(aux_3v3_rail_o) |-> st_r.lock_cnt == LOCK_LOAD)
      else $error("turn-on without lockout load");
   release_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R12]
      (st_r.addr_done && supply_ready_i) |=> !system_hold_n_pd_o)
      else $error("system hold not released when ready");

   ////////////////////////////////////////////////////////////////////////////////
   // A turn-on step of the mode machine: off to any rail, or aux only to all.
   sequence turn_on_s;
      (st_r.mode == PSCPL_OFF && st_nxt.mode != PSCPL_OFF) ||
         (st_r.mode == PSCPL_AUX && st_nxt.mode == PSCPL_ALL);
   endsequence

   // Settled pin requests with the hold pin in charge and no lockout pending.
   sequence all_req_s;
      st_r.ready && !st_r.flt[0] && st_r.flt[1] && !sw_priority_i &&
         st_r.lock_cnt == '0;
   endsequence

   sequence aux_req_s;
      st_r.ready && !st_r.flt[0] && !st_r.flt[1] && !sw_priority_i &&
         st_r.lock_cnt == '0;
   endsequence

   // Software in charge of the main rails and asking for them.
   sequence sw_req_s;
      st_r.ready && !st_r.flt[0] && sw_priority_i && sw_main_on_i &&
         st_r.lock_cnt == '0;
   endsequence

   // The edge at which the slot address is taken.
   sequence addr_taken_s;
      $rose(addr_valid_o);
   endsequence

   lock_wait_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R3]
      turn_on_s |-> st_r.lock_cnt == '0)
      else $error("turn-on inside lockout interval");
   all_on_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R1]
      all_req_s |=> main_rails_on_o && aux_3v3_rail_o)
      else $error("all outputs not on when requested");
   aux_only_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R1]
      aux_req_s |=> aux_3v3_rail_o && !main_rails_on_o)
      else $error("aux only state not reached");
   sw_on_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R13]
      sw_req_s |=> main_rails_on_o)
      else $error("software main request ignored");
   sw_off_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R13]
      (sw_priority_i && !sw_main_on_i) |=> !main_rails_on_o)
      else $error("hold pin overrode software priority");
   en_filt_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R2]
      (st_r.raw[0] != out_enable_n_i) |=> $stable(st_r.flt[0]))
      else $error("enable accepted while still moving");
   hold_filt_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R2]
      (st_r.raw[1] != main_hold_n_i) |=> $stable(st_r.flt[1]))
      else $error("hold accepted while still moving");
   slot_filt_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R5]
      addr_taken_s |-> $past(slot_addr_bit0_n_i, 2) == $past(slot_addr_bit0_n_i) &&
         $past(slot_addr_bit1_n_i, 2) == $past(slot_addr_bit1_n_i))
      else $error("slot address taken from moving pins");
   addr_value_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R4]
      addr_taken_s |-> st_r.addr == ~$past({slot_addr_bit1_n_i, slot_addr_bit0_n_i}))
      else $error("slot address decoded wrongly");
   hold_fall_a: assert property (@(posedge clock_i) disable iff (reset_i) // [R12]
      $fell(system_hold_n_pd_o) |-> $past(supply_ready_i) && $past(addr_valid_o))
      else $error("system hold released before ready");
endmodule

/* File: shared/pscpl_pkg.sv */
// Contract
// [R1] Enable low and hold high: all outputs on; both low: aux rail only; enable high: off.
// [R2] Enable and main-rail hold inputs pass a debounce filter before use.
// [R3] A minimum lockout separates successive turn-on transitions of the outputs.
// [R4] Slot address pins pick I2C address 20h, 21h, 22h or 23h.
// [R5] Slot address pins are debounced before use.
// [R6] Slot address is captured once at power-up and then held.
// [R7] Later slot pin changes are ignored until a full power cycle.
// [R8] Primary and redundant I2C ports share the one latched address.
// [R9] During power-up the fault flag follows the system-hold output.
// [R10] Fault flag is pulled low when any output is out of specification.
// [R11] System-hold is pulled low while the unit powers up.
// [R12] System-hold is released once the supply is ready for control.
// [R13] Hold pin controls outputs only while software priority bit is clear.
// [R14] Debounce and lockout intervals are cycle counts, about 5 ms by default.
// [R15] Each open-drain output is a pull-down enable, high to drive low.
package pscpl_pkg;
   localparam int PSCPL_CLK_MHZ = 250;
   localparam int PSCPL_FILTER_MS = 5;
   localparam int PSCPL_FILTER_CYC = PSCPL_FILTER_MS * 1000 * PSCPL_CLK_MHZ;
   localparam int PSCPL_CNT_W = 21;
   localparam logic [6:0] PSCPL_ADDR_BASE = 7'h20;
   typedef enum logic [1:0] {
      PSCPL_OFF,
      PSCPL_AUX,
      PSCPL_ALL
   } pscpl_out_t;
endpackage

/* File: tb/pscpl_mgr.sv */
`timescale 1ns/10ps
module pscpl_mgr (
   input wire logic enable_req_i,
   input wire logic hold_req_i,
   input wire logic system_hold_n_pd_i,
   input wire logic fault_flag_n_pd_i,
   output logic out_enable_n_o,
   output logic main_hold_n_o,
   output logic system_hold_n_o,
   output logic fault_flag_n_o
);
   assign out_enable_n_o = ~enable_req_i;
   assign main_hold_n_o = ~hold_req_i;
   // Backplane pull-ups bring each released open-drain line high.
   assign system_hold_n_o = ~system_hold_n_pd_i;
   assign fault_flag_n_o = ~fault_flag_n_pd_i;
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
   import pscpl_pkg::*;
   logic clock_i = 1'b0, reset_i = 1'b1, en = 1'b0, hold = 1'b0, s0 = 1'b0, s1 = 1'b0;
   logic prio = 1'b0, swon = 1'b0, rdy = 1'b0, oos = 1'b0, main_on, aux_on, valid, hpd, fpd;
   logic en_n, hold_n, hold_line, fault_line;
   logic [6:0] a_pri, a_red, a_exp;
   int mismatches = 0, checked = 0, seed = 32'he850, r;
   always #2 clock_i = ~clock_i;
   pscpl_mgr pscpl_mgr_i (.enable_req_i(en), .hold_req_i(hold), .system_hold_n_pd_i(hpd),
      .fault_flag_n_pd_i(fpd), .out_enable_n_o(en_n), .main_hold_n_o(hold_n),
      .system_hold_n_o(hold_line), .fault_flag_n_o(fault_line));
   pscpl_ctrl #(.FILTER_CYC(8), .LOCKOUT_CYC(8)) pscpl_ctrl_i (.clock_i(clock_i),
      .reset_i(reset_i), .out_enable_n_i(en_n), .main_hold_n_i(hold_n),
      .slot_addr_bit0_n_i(s0), .slot_addr_bit1_n_i(s1), .sw_priority_i(prio),
      .sw_main_on_i(swon), .supply_ready_i(rdy), .out_of_spec_i(oos),
      .main_rails_on_o(main_on), .aux_3v3_rail_o(aux_on), .i2c_addr_primary_o(a_pri),
      .i2c_addr_redundant_o(a_red), .addr_valid_o(valid), .system_hold_n_pd_o(hpd),
      .fault_flag_n_pd_o(fpd));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [6:0] seen, input logic [6:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task conclude;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Main rails on implies the aux rail on as well.
   function automatic logic [1:0] exp_rails(input logic e, h, p, s);
      if (!e) return 2'b00;
      return (p ? s : !h) ? 2'b11 : 2'b01;
   endfunction
   task automatic wait_rails(input logic [1:0] exp);
      int i;
      for (i = 0; i < 80 && {main_on, aux_on} !== exp; i++) @(negedge clock_i);
      check("rails", {5'h00, main_on, aux_on}, {5'h00, exp});
      if (i == 80) conclude();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      r = $random(seed);
      s0 = r[0];
      s1 = r[1];
      a_exp = 7'h20 + {5'h00, ~s1, ~s0};
      repeat (5) @(negedge clock_i);
      check("hold pd", {6'h00, hpd}, 7'h01);
      check("fault pd", {6'h00, fpd}, 7'h01);
      check("hold line", {6'h00, hold_line}, 7'h00);
      reset_i = 1'b0;
      for (int i = 0; i < 40 && valid !== 1'b1; i++) @(negedge clock_i);
      check("addr valid", {6'h00, valid}, 7'h01);
      if (valid !== 1'b1) conclude();
      check("addr primary", a_pri, a_exp);
      check("addr redundant", a_red, a_exp);
      s0 = ~s0;
      s1 = ~s1;
      repeat (20) @(negedge clock_i);
      check("addr kept", a_pri, a_exp);
      check("hold kept", {6'h00, hpd}, 7'h01);
      $display("test address done");
      rdy = 1'b1;
      repeat (2) @(negedge clock_i);
      check("hold released", {6'h00, hpd}, 7'h00);
      check("hold line up", {6'h00, hold_line}, 7'h01);
      oos = 1'b1;
      @(negedge clock_i);
      check("fault pulled", {6'h00, fpd}, 7'h01);
      check("fault line", {6'h00, fault_line}, 7'h00);
      oos = 1'b0;
      @(negedge clock_i);
      check("fault released", {6'h00, fpd}, 7'h00);
      $display("test flags done");
      hold = 1'b1;
      en = 1'b1;
      repeat (3) @(negedge clock_i);
      en = 1'b0;
      repeat (20) @(negedge clock_i);
      check("glitch", {5'h00, main_on, aux_on}, 7'h00);
      for (int i = 0; i < 10; i++) begin
         r = $random(seed);
         en = (i < 3) ? 1'b1 : r[0];
         hold = (i == 1) ? 1'b0 : r[1];
         prio = (i > 5);
         swon = r[2];
         wait_rails(exp_rails(en, hold, prio, swon));
      end
      $display("test rails done");
      reset_i = 1'b1;
      repeat (5) @(negedge clock_i);
      check("hold pd again", {6'h00, hpd}, 7'h01);
      check("fault pd again", {6'h00, fpd}, 7'h01);
      a_exp = 7'h20 + {5'h00, ~s1, ~s0};
      reset_i = 1'b0;
      for (int i = 0; i < 40 && valid !== 1'b1; i++) @(negedge clock_i);
      check("addr valid again", {6'h00, valid}, 7'h01);
      if (valid !== 1'b1) conclude();
      check("addr after cycle", a_pri, a_exp);
      check("addr redundant again", a_red, a_exp);
      $display("test power cycle done");
      conclude();
   end
endmodule
